/* logic/ecp_edge_det.sv */
// Two-stage synchroniser and edge detector for the timer input pin
`timescale 1ns/100ps
module ecp_edge_det (
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          sys_rst,
	// Pin and edges
	input  wire logic          timer_input_pin,
	output ecp_pkg::ecp_edge_t edge_o
);
	logic sync1_q;
	logic sync2_q;
	logic prev_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
		end else begin
			sync1_q <= timer_input_pin;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	assign edge_o.rise  = sync2_q & ~prev_q;
	assign edge_o.fall  = ~sync2_q & prev_q;
	assign edge_o.level = sync2_q;
endmodule

/* logic/ecp_pkg.sv */
// Constants, register map and carrier types of the event/capture timer
// What this block does
// - Event mode counts on the selected input edge with source 111, else on the prescaled clock
// - Match raises irq, clears counter, keeps counting
// - Match checked on the opposite input edge with source 111, else every cycle
// - Auto-capture copies live count into register B
// - Auto-capture skips zero right after match clear
// - Capture mode counts source clock, edges latch
// - Polarity 0: falling edge latches into B
// - Polarity 0: rising latches A, irq, clears
// - Polarity 1: roles of the two edges swap
// - First edge A-edge: only A, B unchanged
// - Overflow: irq, A loads all ones, clear
// - After overflow capture waits for A read
// - Start bit low stops and clears counter
// - Mode bit: 0 event counter, 1 capture
// - Deep stop clears start bit
package ecp_pkg;
	localparam logic [11:0] ADDR_CTRL  = 12'h000;
	localparam logic [11:0] ADDR_EDGE  = 12'h004;
	localparam logic [11:0] ADDR_CMPA  = 12'h008;
	localparam logic [11:0] ADDR_CAPB  = 12'h00c;
	localparam logic [11:0] ADDR_STAT  = 12'h010;
	localparam logic [11:0] ADDR_COUNT = 12'h014;
	localparam int CTRL_AUTO_CAPTURE_BIT  = 5;
	localparam int CTRL_RUN   = 4;
	localparam int CTRL_MODE  = 3;
	localparam int CTRL_CK_LO = 0;
	localparam logic [7:0] CMPA_RST  = 8'hff;
	localparam logic [7:0] CAPB_RST  = 8'hff;
	localparam logic [7:0] CNT_ALL1  = 8'hff;
	localparam logic [7:0] CNT_ZERO  = 8'h00;
	localparam int DIV_W = 13;
	localparam int IRQ_CYC = 1;

	typedef struct packed {
		logic       auto_capture_bit;
		logic       run;
		logic       mode;
		logic [2:0] src_sel;
	} ecp_ctrl_t;

	typedef struct packed {
		logic rise;
		logic fall;
		logic level;
	} ecp_edge_t;
endpackage

/* logic/ecp_timer.sv */
// 8-bit event counter / pulse capture timer with APB slave
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
module ecp_timer #(
	parameter int CNT_W = 8
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	// APB slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// Pins
	input  wire logic             timer_input_pin,
	input  wire logic             deep_stop,
	output logic                  timer_irq
);
	ecp_pkg::ecp_ctrl_t ctrl_q;
	ecp_pkg::ecp_edge_t edg;
	logic             edge_polarity_bit_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] compare_capture_reg_a_q;
	logic [CNT_W-1:0] capture_reg_b_q;
	logic             cap_hold_q;
	logic             first_q;
	logic             match_pend_q;
	logic [ecp_pkg::DIV_W-1:0] div_q;
	logic             tick;
	logic             cnt_edge;
	logic             opp_edge;
	logic             a_edge;
	logic             b_edge;
	logic             wr_en;
	logic             rd_en;
	logic             rd_a;
	logic             ev_irq;
	logic [31:0]      rd_mux;

	// Source clock select: code n gives clk/2^(13-n); 111 is the pin
	function automatic logic src_tick(input logic [2:0] sel,
		input logic [ecp_pkg::DIV_W-1:0] d, input logic pin_edge);
		logic [ecp_pkg::DIV_W-1:0] m;
		m = '0;
		if (sel == 3'h7) begin
			src_tick = pin_edge;
		end else begin
			m = ecp_pkg::DIV_W'((1 << (13 - int'(sel))) - 1);
			src_tick = ((d & m) == m);
		end
	endfunction

	ecp_edge_det u_edge (
		.clk_sys         (clk_sys),
		.sys_rst         (sys_rst),
		.timer_input_pin (timer_input_pin),
		.edge_o          (edg)
	);

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign rd_a  = rd_en & (paddr == ecp_pkg::ADDR_CMPA);
	// Count edge is rising when polarity is 0
	assign cnt_edge = edge_polarity_bit_q ? edg.fall : edg.rise;
	assign opp_edge = edge_polarity_bit_q ? edg.rise : edg.fall;
	assign a_edge = edge_polarity_bit_q ? edg.fall : edg.rise;
	assign b_edge = edge_polarity_bit_q ? edg.rise : edg.fall;
	assign tick = src_tick(ctrl_q.src_sel, div_q, cnt_edge);

	// Prescaler runs only while started so each start is aligned
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !ctrl_q.run) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// Control register; deep stop forces the start bit low
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_q <= '0;
			edge_polarity_bit_q <= 1'b0;
		end else begin
			if (wr_en && paddr == ecp_pkg::ADDR_CTRL) begin
				ctrl_q.auto_capture_bit <= pwdata[ecp_pkg::CTRL_AUTO_CAPTURE_BIT];
				ctrl_q.run  <= pwdata[ecp_pkg::CTRL_RUN];
				ctrl_q.mode <= pwdata[ecp_pkg::CTRL_MODE];
				ctrl_q.src_sel <=
					pwdata[ecp_pkg::CTRL_CK_LO +: 3];
			end
			if (wr_en && paddr == ecp_pkg::ADDR_EDGE) begin
				edge_polarity_bit_q <= pwdata[0];
			end
			if (deep_stop) begin
				ctrl_q.run <= 1'b0;
			end
		end
	end

	// Up-counter, match and capture engine
	always_ff @(posedge clk_sys) begin
		ev_irq <= 1'b0;
		if (sys_rst) begin
			cnt_q <= '0;
			compare_capture_reg_a_q <= ecp_pkg::CMPA_RST;
			capture_reg_b_q <= ecp_pkg::CAPB_RST;
			cap_hold_q <= 1'b0;
			first_q <= 1'b1;
			match_pend_q <= 1'b0;
		end else if (!ctrl_q.run) begin
			cnt_q <= '0;
			first_q <= 1'b1;
			match_pend_q <= 1'b0;
			cap_hold_q <= 1'b0;
			if (wr_en && paddr == ecp_pkg::ADDR_CMPA) begin
				compare_capture_reg_a_q <= pwdata[CNT_W-1:0];
			end
		end else if (!ctrl_q.mode) begin
			if (tick) begin
				cnt_q <= cnt_q + 1'b1;
			end
			// Auto-capture first, so a match in the same cycle wins pend
			if (ctrl_q.auto_capture_bit) begin
				if (match_pend_q && cnt_q == ecp_pkg::CNT_ZERO) begin
					match_pend_q <= match_pend_q;
				end else begin
					capture_reg_b_q <= cnt_q;
					match_pend_q <= 1'b0;
				end
			end
			if (ctrl_q.src_sel == 3'h7) begin
				// Match only evaluated on the opposite edge
				if (opp_edge && cnt_q == compare_capture_reg_a_q) begin
					ev_irq <= 1'b1;
					cnt_q <= '0;
					match_pend_q <= 1'b1;
				end
			end else if (cnt_q == compare_capture_reg_a_q) begin
				ev_irq <= 1'b1;
				cnt_q <= '0;
				match_pend_q <= 1'b1;
			end
		end else begin
			if (rd_a) begin
				cap_hold_q <= 1'b0;
			end
			if (tick) begin
				cnt_q <= cnt_q + 1'b1;
			end
			if (!cap_hold_q) begin
				if (a_edge) begin
					compare_capture_reg_a_q <= cnt_q;
					ev_irq <= 1'b1;
					cnt_q <= '0;
					first_q <= 1'b0;
				end else if (b_edge) begin
					capture_reg_b_q <= cnt_q;
					first_q <= 1'b0;
				end else if (tick && cnt_q == ecp_pkg::CNT_ALL1) begin
					compare_capture_reg_a_q <= ecp_pkg::CNT_ALL1;
					ev_irq <= 1'b1;
					cnt_q <= '0;
					cap_hold_q <= 1'b1;
				end
			end
		end
	end

	// Interrupt as a registered one-cycle pulse
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= ev_irq;
		end
	end

	always_comb begin
		rd_mux = '0;
		case (paddr)
			ecp_pkg::ADDR_CTRL: begin
				rd_mux[5:0] = {ctrl_q.auto_capture_bit, ctrl_q.run, ctrl_q.mode,
					ctrl_q.src_sel};
			end
			ecp_pkg::ADDR_EDGE:  rd_mux[0] = edge_polarity_bit_q;
			ecp_pkg::ADDR_CMPA:  rd_mux[7:0] = compare_capture_reg_a_q;
			ecp_pkg::ADDR_CAPB:  rd_mux[7:0] = capture_reg_b_q;
			ecp_pkg::ADDR_STAT:  rd_mux[1:0] = {first_q, cap_hold_q};
			ecp_pkg::ADDR_COUNT: rd_mux[7:0] = cnt_q;
			default:             rd_mux = '0;
		endcase
	end

	// APB: no wait state; the reply is registered in the setup cycle, so every output comes from a flop
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			prdata  <= rd_mux;
			pslverr <= psel & ~penable & (paddr > ecp_pkg::ADDR_COUNT);
		end
	end

	AST_CNT_CLR_STOP: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ctrl_q.run |=> cnt_q == '0) else $error("counter not cleared");
	AST_DSTOP: assert property (@(posedge clk_sys) disable iff (sys_rst)
		deep_stop |=> !ctrl_q.run) else $error("deep stop kept run");
	AST_IRQ_PULSE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ev_irq |=> timer_irq) else $error("irq missing");
	AST_CAP_A: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ctrl_q.run && ctrl_q.mode && !cap_hold_q && a_edge) |=>
		(compare_capture_reg_a_q == $past(cnt_q) && cnt_q == '0))
		else $error("capture into A wrong");
	AST_OVF_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ctrl_q.run && ctrl_q.mode && !cap_hold_q && !a_edge && !b_edge
		&& tick && cnt_q == ecp_pkg::CNT_ALL1) |=>
		(cap_hold_q && compare_capture_reg_a_q == ecp_pkg::CNT_ALL1))
		else $error("overflow not held");
	AST_AUTO_CAPTURE_BIT_SKIP: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ctrl_q.run && !ctrl_q.mode && ctrl_q.auto_capture_bit && match_pend_q
		&& cnt_q == ecp_pkg::CNT_ZERO) |=> $stable(capture_reg_b_q))
		else $error("zero after match captured");
endmodule

/* verification/ecp_pulse_src.sv */
// Behavioural pulse source that drives the timer input pin
`timescale 1ns/100ps
module ecp_pulse_src #(
	parameter int PHASE = 8
) (
	// Clock and control
	input  wire logic clk_sys,
	input  wire logic go,
	// Pin
	output logic      timer_input_pin
);
	int cnt_q = 0;
	initial timer_input_pin = 1'b0;
	// Pin stands still while idle, so no stray edge reaches the timer
	always @(posedge clk_sys) begin
		if (!go) begin
			cnt_q <= 0;
		end else if (cnt_q == PHASE - 1) begin
			cnt_q           <= 0;
			timer_input_pin <= !timer_input_pin;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule

/* verification/ecp_timer_tb.sv */
// Self-checking bench for the event/capture timer
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected at %0t got %h exp %h", $time, g, e); end end
module ecp_timer_tb;
	logic        clk_sys    = 1'b0;
	logic        sys_rst    = 1'b1;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [11:0] paddr      = 12'h000;
	logic [31:0] pwdata     = 32'h0;
	logic        deep_stop  = 1'b0;
	logic        go         = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin;
	logic        timer_irq;
	logic [8:0]  exp_q[$];
	logic [31:0] seed       = 32'h995e4586;
	logic [7:0]  k;
	int          num_errors = 0;
	int          compares   = 0;
	int          irqs       = 0;
	always #20 clk_sys = !clk_sys;
	ecp_timer i_ecp_timer (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_input_pin(pin), .deep_stop(deep_stop),
		.timer_irq(timer_irq));
	ecp_pulse_src i_ecp_pulse_src (.clk_sys(clk_sys), .go(go),
		.timer_input_pin(pin));
	always @(posedge clk_sys) begin
		if (timer_irq === 1'b1)
			irqs++;
		// Read data is taken only at the sampled completion edge
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			`CHK(pslverr ? 9'h100 : {1'b0, prdata[7:0]}, exp_q.pop_front())
		end
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic test_done();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= (xs() & 32'hffffc000) | {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			test_done();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [8:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 8'h00);
	endtask
	// Lets the source make m pin toggles, then settle
	task automatic ph(input int m);
		go <= 1'b1;
		repeat (m * 8) @(posedge clk_sys);
		go <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd(ecp_pkg::ADDR_CMPA, 9'h0ff);
		rd(12'h018, 9'h100);
		$display("reset and map test done");
		k = 8'h03 + 8'(xs() % 4);
		wr(ecp_pkg::ADDR_EDGE, 8'h00);
		wr(ecp_pkg::ADDR_CTRL, 8'h07);
		wr(ecp_pkg::ADDR_CMPA, k);
		wr(ecp_pkg::ADDR_CTRL, 8'h37);
		ph(4);
		rd(ecp_pkg::ADDR_CAPB, 9'h002);
		rd(ecp_pkg::ADDR_COUNT, 9'h002);
		ph(2 * k - 5);
		`CHK(irqs, 0)
		ph(1);
		`CHK(irqs, 1)
		rd(ecp_pkg::ADDR_COUNT, 9'h000);
		rd(ecp_pkg::ADDR_CAPB, {1'b0, k});
		$display("event test done");
		wr(ecp_pkg::ADDR_CTRL, 8'h0e);
		wr(ecp_pkg::ADDR_CTRL, 8'h1e);
		ph(1);
		`CHK(irqs, 2)
		rd(ecp_pkg::ADDR_CAPB, {1'b0, k});
		wr(ecp_pkg::ADDR_CTRL, 8'h0e);
		wr(ecp_pkg::ADDR_CTRL, 8'h1e);
		for (int i = 0; i < 40000 && irqs < 3; i++)
			@(posedge clk_sys);
		`CHK(irqs, 3)
		rd(ecp_pkg::ADDR_CAPB, {1'b0, k});
		rd(ecp_pkg::ADDR_CMPA, 9'h0ff);
		$display("capture test done");
		wr(ecp_pkg::ADDR_CTRL, 8'h0e);
		wr(ecp_pkg::ADDR_EDGE, 8'h01);
		wr(ecp_pkg::ADDR_CTRL, 8'h1e);
		ph(1);
		`CHK(irqs, 4)
		rd(ecp_pkg::ADDR_CAPB, {1'b0, k});
		deep_stop <= 1'b1;
		@(posedge clk_sys);
		deep_stop <= 1'b0;
		rd(ecp_pkg::ADDR_CTRL, 9'h00e);
		rd(ecp_pkg::ADDR_COUNT, 9'h000);
		$display("stop test done");
		test_done();
	end
endmodule
